// *** bench/test_reset_and_power_mode_control.sv ***
`timescale 1ns/1ps
module test_reset_and_power_mode_control;
	logic mclk, rst_n, clk_en, hsel, hwrite, hready, pin_reset_evt, por_evt;
	logic [31:0] haddr, hwdata, hrdata, lp_powerdown, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, irq, soft_reset, hs_clk_off, conv_switch_on, sram_powered;
	logic seq_autosleep_en, tmr_autosleep_en, lf_clk_switch_en;
	int fail_count, samples_checked, pulse_count;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	rpm_top dut (
		.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pin_reset_evt(pin_reset_evt), .por_evt(por_evt), .irq(irq),
		.soft_reset(soft_reset), .hs_clk_off(hs_clk_off),
		.conv_switch_on(conv_switch_on), .sram_powered(sram_powered),
		.seq_autosleep_en(seq_autosleep_en), .tmr_autosleep_en(tmr_autosleep_en),
		.lf_clk_switch_en(lf_clk_switch_en), .lp_powerdown(lp_powerdown)
	);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// counts reset pulses, so a missed or doubled pulse shows up
	always @(posedge mclk) begin
		if (soft_reset === 1'b1) pulse_count <= pulse_count + 1;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask : check
	// bounded wait for ready sampled high at a rising edge
	task wait_rdy;
		int n;
		n = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (n >= 50) fail_count++;
	endtask : wait_rdy
	task bus_wr(input logic [13:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {18'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask : bus_wr
	task rd_chk(input logic [13:0] a, input logic [31:0] exp);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {18'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		wait_rdy();
		rd = hrdata;
		check(rd, exp);
	endtask : rd_chk
	task pkey;
		bus_wr(14'h0A04, 32'h00004859);
		bus_wr(14'h0A04, 32'h0000F27B);
	endtask : pkey
	task test_reset_values;
		rd_chk(14'h0424, 32'h00000001);
		rd_chk(14'h0A00, 32'h00000001);
		rd_chk(14'h0A04, 32'h00000000);
		rd_chk(14'h0A40, 32'h00000000);
		rd_chk(14'h210C, 32'h00000000);
		rd_chk(14'h2110, 32'h00000000);
		rd_chk(14'h2114, 32'h00000102);
		rd_chk(14'h2200, 32'h00000000);
		check(lp_powerdown, 32'h00000102);
		check(32'(hs_clk_off), 32'h0);
		check(32'(hresp), 32'h0);
	endtask : test_reset_values
	task test_soft_reset;
		bus_wr(14'h0424, 32'h0000A158);
		rd_chk(14'h0A40, 32'h00000000);
		bus_wr(14'h0A5C, 32'h000012EB);
		bus_wr(14'h0424, 32'h0000A158);
		check(32'(pulse_count), 32'h0);
		// an intervening write must close the reset key again
		bus_wr(14'h0A5C, 32'h000012EA);
		bus_wr(14'h0A04, 32'h00000000);
		bus_wr(14'h0424, 32'h0000A158);
		check(32'(pulse_count), 32'h0);
		bus_wr(14'h0A5C, 32'h000012EA);
		bus_wr(14'h0424, 32'h0000A158);
		repeat (2) @(posedge mclk);
		check(32'(pulse_count), 32'h1);
		rd_chk(14'h0A40, 32'h00000008);
		rd_chk(14'h3000, 32'h00000001);
		bus_wr(14'h0A5C, 32'h000012EA);
		bus_wr(14'h0424, 32'h00000000);
		repeat (2) @(posedge mclk);
		check(32'(pulse_count), 32'h1);
		bus_wr(14'h0A40, 32'h00000008);
		rd_chk(14'h0A40, 32'h00000000);
		bus_wr(14'h3004, 32'h00000001);
	endtask : test_soft_reset
	task test_events_irq;
		bus_wr(14'h3008, 32'h00000006);
		@(posedge mclk);
		pin_reset_evt <= 1'b1;
		// event input passes a two-flop synchroniser first
		repeat (6) @(posedge mclk);
		pin_reset_evt <= 1'b0;
		rd_chk(14'h0A40, 32'h00000002);
		check(32'(irq), 32'h1);
		bus_wr(14'h3008, 32'h00000000);
		repeat (2) @(posedge mclk);
		check(32'(irq), 32'h0);
		rd_chk(14'h3000, 32'h00000002);
		bus_wr(14'h3008, 32'h00000006);
		bus_wr(14'h3004, 32'h00000002);
		repeat (2) @(posedge mclk);
		check(32'(irq), 32'h0);
		por_evt <= 1'b1;
		repeat (6) @(posedge mclk);
		por_evt <= 1'b0;
		check(32'(irq), 32'h1);
		bus_wr(14'h0A40, 32'h00000002);
		rd_chk(14'h0A40, 32'h00000001);
		bus_wr(14'h0A40, 32'h00000001);
		bus_wr(14'h3004, 32'h00000004);
		rd_chk(14'h0A40, 32'h00000000);
		rd_chk(14'h3000, 32'h00000000);
		check(32'(irq), 32'h0);
	endtask : test_events_irq
	task test_power_mode;
		bus_wr(14'h0A00, 32'h00000002);
		rd_chk(14'h0A00, 32'h00000001);
		pkey();
		bus_wr(14'h0A00, 32'h0000C002);
		rd_chk(14'h0A00, 32'h0000C002);
		check({29'h0, hs_clk_off, conv_switch_on, sram_powered}, 32'h7);
		pkey();
		bus_wr(14'h0A00, 32'h00000002);
		rd_chk(14'h0A00, 32'h00000002);
		check({29'h0, hs_clk_off, conv_switch_on, sram_powered}, 32'h4);
		pkey();
		bus_wr(14'h2200, 32'h00000000);
		bus_wr(14'h0A00, 32'h00000001);
		rd_chk(14'h0A00, 32'h00000002);
		bus_wr(14'h0A04, 32'h0000F27B);
		bus_wr(14'h0A04, 32'h00004859);
		bus_wr(14'h0A00, 32'h00000001);
		rd_chk(14'h0A00, 32'h00000002);
		// reserved code is kept for read back but must not leave hibernate
		pkey();
		bus_wr(14'h0A00, 32'h00000003);
		rd_chk(14'h0A00, 32'h00000003);
		check(32'(hs_clk_off), 32'h1);
		pkey();
		// software leaves hibernate itself before the high power sequence
		bus_wr(14'h0A00, 32'h0000000D);
		rd_chk(14'h0A00, 32'h0000000D);
		check({29'h0, hs_clk_off, seq_autosleep_en, tmr_autosleep_en}, 32'h3);
	endtask : test_power_mode
	task test_low_power;
		bus_wr(14'h2114, 32'h00000000);
		rd_chk(14'h2114, 32'h00000102);
		bus_wr(14'h210C, 32'h000C59D6);
		bus_wr(14'h2114, 32'h0000000F);
		bus_wr(14'h2110, 32'h00000001);
		rd_chk(14'h2114, 32'h0000000F);
		rd_chk(14'h2110, 32'h00000001);
		check(lp_powerdown, 32'h0000000F);
		check(32'(lf_clk_switch_en), 32'h1);
		bus_wr(14'h210C, 32'h00000000);
		bus_wr(14'h2114, 32'h00000000);
		rd_chk(14'h2114, 32'h0000000F);
		bus_wr(14'h210C, 32'h000C59D7);
		bus_wr(14'h2110, 32'h00000000);
		rd_chk(14'h2110, 32'h00000001);
	endtask : test_low_power
	// clock enable low must freeze the event synchroniser too
	task test_freeze;
		@(posedge mclk);
		clk_en <= 1'b0;
		por_evt <= 1'b1;
		repeat (4) @(posedge mclk);
		por_evt <= 1'b0;
		repeat (2) @(posedge mclk);
		clk_en <= 1'b1;
		rd_chk(14'h0A40, 32'h00000000);
	endtask : test_freeze
	task test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pin_reset_evt = 1'b0;
		por_evt = 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		test_reset_values();
		test_soft_reset();
		test_events_irq();
		test_power_mode();
		test_low_power();
		test_freeze();
		test_done();
	end
	// whole run is well under a thousand cycles; this only catches a hang
	initial begin
		#500000;
		fail_count++;
		test_done();
	end
endmodule : test_reset_and_power_mode_control

// *** design/rpm_key_guard.sv ***
`timescale 1ns/1ps
module rpm_key_guard (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	rpm_wr_if.guard wb // accepted register writes
);
	rpm_pkg::rpm_pkey_t pk_state;
	logic key1;
	logic key2;

	// key matches on the power key register
	assign key1 = wb.addr == rpm_pkg::OFS_POWER_MODE_KEY && wb.data[15:0] == rpm_pkg::KEY_PWR1;
	assign key2 = wb.addr == rpm_pkg::OFS_POWER_MODE_KEY && wb.data[15:0] == rpm_pkg::KEY_PWR2;
	assign wb.pwr_open = pk_state == rpm_pkg::PK_OPEN;

	// reset key arms only for the very next write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb.rst_open <= 1'b0;
		end else if (wb.wr) begin
			wb.rst_open <= wb.addr == rpm_pkg::OFS_RSTKEY && wb.data[15:0] == rpm_pkg::KEY_RST; // RULE_01 RULE_02 RULE_18
		end
	end

	// power key: two codes in order, then the mode write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pk_state <= rpm_pkg::PK_LOCKED;
		end else if (wb.wr) begin
			unique case (pk_state)
				rpm_pkg::PK_LOCKED, rpm_pkg::PK_OPEN: begin
					pk_state <= key1 ? rpm_pkg::PK_FIRST : rpm_pkg::PK_LOCKED; // RULE_16
				end
				rpm_pkg::PK_FIRST: begin
					pk_state <= key2 ? rpm_pkg::PK_OPEN : (key1 ? rpm_pkg::PK_FIRST : rpm_pkg::PK_LOCKED); // RULE_16 RULE_18
				end
				default: begin
					pk_state <= rpm_pkg::PK_LOCKED;
				end
			endcase
		end
	end

	// low-power key stays open until another value is written
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb.lp_open <= 1'b0;
		end else if (wb.wr && wb.addr == rpm_pkg::OFS_LPKEY) begin
			wb.lp_open <= wb.data[19:0] == rpm_pkg::KEY_LP; // RULE_14 RULE_18
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_rst_relock: assert property (wb.wr && wb.addr != rpm_pkg::OFS_RSTKEY |=> !wb.rst_open) // RULE_02
		else $error("reset key stayed open after another write");
	chk_pwr_order: assert property ($rose(wb.pwr_open) |-> $past(key2) && $past(wb.wr)) // RULE_16
		else $error("power key opened without second code");
	chk_lp_badkey: assert property (wb.wr && wb.addr == rpm_pkg::OFS_LPKEY && wb.data[19:0] != rpm_pkg::KEY_LP |=> !wb.lp_open) // RULE_18
		else $error("low power key open after wrong code");
endmodule : rpm_key_guard

// *** design/rpm_pkg.sv ***
package rpm_pkg;
	// register window decode width
	localparam int ADDR_W = 14;
	localparam logic [13:0] OFS_SWRST = 14'h0424;
	localparam logic [13:0] OFS_POWER_MODE_CONFIG = 14'h0A00;
	localparam logic [13:0] OFS_POWER_MODE_KEY = 14'h0A04;
	localparam logic [13:0] OFS_RESET_SOURCE_STATUS = 14'h0A40;
	localparam logic [13:0] OFS_RSTKEY = 14'h0A5C;
	localparam logic [13:0] OFS_LPKEY = 14'h210C;
	localparam logic [13:0] OFS_LPCLK = 14'h2110;
	localparam logic [13:0] OFS_LPCON = 14'h2114;
	localparam logic [13:0] OFS_INTSTA = 14'h3000;
	localparam logic [13:0] OFS_INTCLR = 14'h3004;
	localparam logic [13:0] OFS_INTEN = 14'h3008;
	// decode value that no register owns
	localparam logic [13:0] OFS_NONE = 14'h3FFF;
	// unlock and trigger codes
	localparam logic [15:0] KEY_RST = 16'h12EA;
	localparam logic [15:0] KEY_TRIG = 16'hA158;
	localparam logic [15:0] KEY_PWR1 = 16'h4859;
	localparam logic [15:0] KEY_PWR2 = 16'hF27B;
	localparam logic [19:0] KEY_LP = 20'hC59D6;
	// reset values and writable masks
	localparam logic [15:0] SWRST_RST = 16'h0001;
	localparam logic [15:0] POWER_MODE_CONFIG_RST = 16'h0001;
	localparam logic [15:0] POWER_MODE_CONFIG_MASK = 16'hC00F;
	localparam logic [15:0] RESET_SOURCE_STATUS_MASK = 16'h000B;
	localparam logic [31:0] LPCON_RST = 32'h00000102;
	// field positions
	localparam int STA_POR = 0;
	localparam int STA_PIN = 1;
	localparam int STA_SOFT = 3;
	localparam int PM_TMR = 2;
	localparam int PM_SEQ = 3;
	localparam int PM_CONV = 14;
	localparam int PM_RAM = 15;
	localparam int INT_W = 3;
	localparam int INT_SOFT = 0;
	localparam int INT_PIN = 1;
	localparam int INT_POR = 2;
	// bus codes
	localparam logic [2:0] SIZE_WORD = 3'h2;
	typedef enum logic [1:0] {PK_LOCKED = 2'b00, PK_FIRST = 2'b01, PK_OPEN = 2'b10} rpm_pkey_t;
	typedef enum logic [1:0] {MODE_ACTIVE = 2'b01, MODE_HIBERNATE = 2'b10} rpm_mode_t;
endpackage : rpm_pkg

// *** design/rpm_top.sv ***
// Behaviour
// RULE_01: reset control writable only after its key
// RULE_02: any other write relocks reset key
// RULE_03: unlocked write of trigger code fires reset
// RULE_04: reset control write sets soft reset flag
// RULE_05: pin reset sets its flag, write-one clears
// RULE_06: power-on sets its flag, write-one clears
// RULE_07: software sequences high power mode itself
// RULE_08: default is active mode, field reads one
// RULE_09: mode code two enters hibernate, clocks off
// RULE_10: bit fourteen keeps converter switch on
// RULE_11: bit fifteen keeps memory during hibernate
// RULE_12: shutdown is hibernate plus software powerdowns
// RULE_13: powerdown bits power blocks down, reset value
// RULE_14: low power registers need their key first
// RULE_15: clock select bit permits slow clock switch
// RULE_16: two power codes then mode write directly
// RULE_17: reserved mode code ignored, read back kept
// RULE_18: wrong key or locked write is ignored
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module rpm_top (
	input wire logic mclk, // system clock, 40 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic clk_en, // freezes all state while low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire logic pin_reset_evt, // pin reset happened, async level
	input wire logic por_evt, // power-on reset happened, async level
	output logic irq, // level interrupt
	output logic soft_reset, // digital reset pulse
	output logic hs_clk_off, // high speed clocks powered down
	output logic conv_switch_on, // converter power switch
	output logic sram_powered, // memory supply kept
	output logic seq_autosleep_en, // sequencer autosleep
	output logic tmr_autosleep_en, // timer autosleep
	output logic lf_clk_switch_en, // slow clock switch permitted
	output logic [31:0] lp_powerdown // per-block powerdown
);
	localparam int INT_W_L = rpm_pkg::INT_W;
	rpm_wr_if wb ();
	logic dp_wr;
	logic dp_rd;
	logic dp_map;
	logic [13:0] dp_addr;
	logic ap_valid;
	logic [31:0] rd_mux;
	logic [15:0] swrst;
	logic [15:0] power_mode_config;
	logic [15:0] power_mode_key;
	logic [15:0] reset_source_status;
	logic [19:0] lpkey;
	logic [1:0] eff_mode;
	logic [INT_W_L-1:0] intsta;
	logic [INT_W_L-1:0] inten;
	logic [1:0] evt_s1;
	logic [1:0] evt_s2;
	logic [1:0] evt_s3;
	logic [1:0] evt_rise;
	logic sw_acc;
	logic sw_trig;
	logic pm_acc;
	logic [15:0] next_reset_source_status;
	logic [INT_W_L-1:0] next_intsta;
	logic [INT_W_L-1:0] int_set;

	rpm_key_guard u_guard (
		.mclk(mclk),
		.rst_n(rst_n),
		.wb(wb.guard)
	);

	function automatic logic hit(input logic [13:0] ofs);
		return wb.wr && wb.addr == ofs;
	endfunction : hit

	// bus write stream; unmapped writes still relock the reset and power keys
	assign ap_valid = hsel && htrans[1] && hready;
	assign wb.wr = clk_en && dp_wr && hready;
	assign wb.addr = dp_map ? dp_addr : rpm_pkg::OFS_NONE;
	assign wb.data = hwdata;

	// accepted writes to the protected registers
	assign sw_acc = wb.rst_open && hit(rpm_pkg::OFS_SWRST); // RULE_01
	assign sw_trig = sw_acc && wb.data[15:0] == rpm_pkg::KEY_TRIG; // RULE_03
	assign pm_acc = wb.pwr_open && hit(rpm_pkg::OFS_POWER_MODE_CONFIG); // RULE_16
	assign evt_rise = evt_s2 & ~evt_s3;

	// address phase capture; only word writes are honoured
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr <= 1'b0;
			dp_rd <= 1'b0;
			dp_map <= 1'b0;
			dp_addr <= 14'h0000;
		end else if (clk_en && hready) begin
			dp_wr <= ap_valid && hwrite && hsize == rpm_pkg::SIZE_WORD;
			dp_rd <= ap_valid && !hwrite;
			dp_map <= haddr[31:rpm_pkg::ADDR_W] == 18'h00000 && haddr[1:0] == 2'h0;
			dp_addr <= haddr[13:0];
		end
	end

	// reads take one wait state so a preceding write is visible
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
		end else if (clk_en) begin
			hreadyout <= !(ap_valid && !hwrite);
			if (dp_rd && !hreadyout) begin
				hrdata <= dp_map ? rd_mux : 32'h00000000;
			end
		end
	end

	// error response is never used
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// read mux; keys that are write-only read zero
	always_comb begin
		unique case (dp_addr)
			rpm_pkg::OFS_SWRST: rd_mux = {16'h0000, swrst};
			rpm_pkg::OFS_POWER_MODE_CONFIG: rd_mux = {16'h0000, power_mode_config}; // RULE_17
			rpm_pkg::OFS_POWER_MODE_KEY: rd_mux = {16'h0000, power_mode_key};
			rpm_pkg::OFS_RESET_SOURCE_STATUS: rd_mux = {16'h0000, reset_source_status};
			rpm_pkg::OFS_LPKEY: rd_mux = {12'h000, lpkey};
			rpm_pkg::OFS_LPCLK: rd_mux = {31'h00000000, lf_clk_switch_en};
			rpm_pkg::OFS_LPCON: rd_mux = lp_powerdown;
			rpm_pkg::OFS_INTSTA: rd_mux = {29'h00000000, intsta};
			rpm_pkg::OFS_INTEN: rd_mux = {29'h00000000, inten};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// reset cause pins cross in through two flops, third finds the edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			evt_s1 <= 2'h0;
			evt_s2 <= 2'h0;
			evt_s3 <= 2'h0;
		end else if (clk_en) begin
			evt_s1 <= {pin_reset_evt, por_evt};
			evt_s2 <= evt_s1;
			evt_s3 <= evt_s2;
		end
	end

	// software reset register and its trigger pulse
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			swrst <= rpm_pkg::SWRST_RST; // RULE_03
			soft_reset <= 1'b0;
		end else if (clk_en) begin
			soft_reset <= sw_trig; // RULE_03
			if (sw_acc) begin
				swrst <= wb.data[15:0]; // RULE_01 RULE_18
			end
		end
	end

	// reset cause flags; a new event beats a same-cycle clear
	always_comb begin
		next_reset_source_status = reset_source_status;
		if (hit(rpm_pkg::OFS_RESET_SOURCE_STATUS)) begin
			next_reset_source_status = reset_source_status & ~wb.data[15:0];
		end
		next_reset_source_status[rpm_pkg::STA_SOFT] = next_reset_source_status[rpm_pkg::STA_SOFT] | sw_acc; // RULE_04
		next_reset_source_status[rpm_pkg::STA_PIN] = next_reset_source_status[rpm_pkg::STA_PIN] | evt_rise[1]; // RULE_05
		next_reset_source_status[rpm_pkg::STA_POR] = next_reset_source_status[rpm_pkg::STA_POR] | evt_rise[0]; // RULE_06
		next_reset_source_status = next_reset_source_status & rpm_pkg::RESET_SOURCE_STATUS_MASK;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reset_source_status <= 16'h0000; // RULE_06
		end else if (clk_en) begin
			reset_source_status <= next_reset_source_status;
		end
	end

	// power mode register; reserved codes stored but not acted on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode_config <= rpm_pkg::POWER_MODE_CONFIG_RST; // RULE_08 RULE_11
			eff_mode <= rpm_pkg::MODE_ACTIVE; // RULE_08
		end else if (clk_en && pm_acc) begin
			power_mode_config <= wb.data[15:0] & rpm_pkg::POWER_MODE_CONFIG_MASK; // RULE_16
			if (wb.data[1:0] == rpm_pkg::MODE_ACTIVE || wb.data[1:0] == rpm_pkg::MODE_HIBERNATE) begin
				eff_mode <= wb.data[1:0]; // RULE_09 RULE_17
			end
		end
	end

	// key registers kept for read-back
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode_key <= 16'h0000;
			lpkey <= 20'h00000;
		end else if (clk_en) begin
			if (hit(rpm_pkg::OFS_POWER_MODE_KEY)) begin
				power_mode_key <= wb.data[15:0];
			end
			if (hit(rpm_pkg::OFS_LPKEY)) begin
				lpkey <= wb.data[19:0];
			end
		end
	end

	// low power registers, writable only behind their key
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lf_clk_switch_en <= 1'b0;
			lp_powerdown <= rpm_pkg::LPCON_RST; // RULE_13
		end else if (clk_en && wb.lp_open) begin
			if (hit(rpm_pkg::OFS_LPCLK)) begin
				lf_clk_switch_en <= wb.data[0]; // RULE_14 RULE_15
			end
			if (hit(rpm_pkg::OFS_LPCON)) begin
				lp_powerdown <= wb.data; // RULE_13 RULE_14
			end
		end
	end

	// power controls follow the effective mode and the mode register bits one cycle later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hs_clk_off <= 1'b0;
			conv_switch_on <= 1'b1;
			sram_powered <= 1'b1;
			seq_autosleep_en <= 1'b0;
			tmr_autosleep_en <= 1'b0;
		end else if (clk_en) begin
			hs_clk_off <= eff_mode == rpm_pkg::MODE_HIBERNATE; // RULE_09
			conv_switch_on <= eff_mode != rpm_pkg::MODE_HIBERNATE || power_mode_config[rpm_pkg::PM_CONV]; // RULE_10
			sram_powered <= eff_mode != rpm_pkg::MODE_HIBERNATE || power_mode_config[rpm_pkg::PM_RAM]; // RULE_11
			seq_autosleep_en <= power_mode_config[rpm_pkg::PM_SEQ];
			tmr_autosleep_en <= power_mode_config[rpm_pkg::PM_TMR];
		end
	end

	// interrupt events; set beats a same-cycle clear
	assign int_set = {evt_rise[0], evt_rise[1], sw_trig};
	always_comb begin
		next_intsta = intsta;
		if (hit(rpm_pkg::OFS_INTCLR)) begin
			next_intsta = intsta & ~wb.data[INT_W_L-1:0];
		end
		next_intsta = next_intsta | int_set;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			intsta <= 3'h0;
			inten <= 3'h0;
			irq <= 1'b0;
		end else if (clk_en) begin
			intsta <= next_intsta;
			irq <= |(intsta & inten);
			if (hit(rpm_pkg::OFS_INTEN)) begin
				inten <= wb.data[INT_W_L-1:0];
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	chk_swrst_locked: assert property (hit(rpm_pkg::OFS_SWRST) && !wb.rst_open |=> $stable(swrst)) // RULE_18
		else $error("locked reset control changed");
	chk_trig_pulse: assert property ($rose(soft_reset) |-> $past(sw_acc) && $past(wb.data[15:0]) == rpm_pkg::KEY_TRIG) // RULE_03
		else $error("reset pulse without unlocked trigger");
	chk_soft_flag: assert property (sw_acc |=> reset_source_status[rpm_pkg::STA_SOFT]) // RULE_04
		else $error("soft reset flag not set");
	chk_pin_flag: assert property (clk_en && evt_rise[1] |=> reset_source_status[rpm_pkg::STA_PIN]) // RULE_05
		else $error("pin reset flag not set");
	chk_por_flag: assert property (clk_en && evt_rise[0] |=> reset_source_status[rpm_pkg::STA_POR]) // RULE_06
		else $error("power-on flag not set");
	chk_hib_entry: assert property (pm_acc && wb.data[1:0] == rpm_pkg::MODE_HIBERNATE ##1 clk_en |=> hs_clk_off) // RULE_09
		else $error("hibernate not entered");
	chk_reserved_mode: assert property (pm_acc && wb.data[1:0] == 2'h3 |=> $stable(eff_mode) && power_mode_config[1:0] == 2'h3) // RULE_17
		else $error("reserved mode acted on or not read back");
	chk_conv_switch: assert property ($past(clk_en) && $past(eff_mode) == rpm_pkg::MODE_HIBERNATE && !$past(power_mode_config[rpm_pkg::PM_CONV]) |-> !conv_switch_on) // RULE_10
		else $error("converter switch on in hibernate");
	chk_lp_locked: assert property ((hit(rpm_pkg::OFS_LPCON) || hit(rpm_pkg::OFS_LPCLK)) && !wb.lp_open |=> $stable(lp_powerdown) && $stable(lf_clk_switch_en)) // RULE_14
		else $error("locked low power register changed");

	cov_soft_reset: cover property (sw_trig);
	cov_hibernate: cover property (pm_acc && wb.data[1:0] == rpm_pkg::MODE_HIBERNATE);
	cov_irq: cover property ($rose(irq));
	cov_read_wait: cover property (dp_rd && !hreadyout);
endmodule : rpm_top

// *** design/rpm_wr_if.sv ***
`timescale 1ns/1ps
interface rpm_wr_if;
	logic wr;
	logic [13:0] addr;
	logic [31:0] data;
	logic rst_open;
	logic pwr_open;
	logic lp_open;
	modport bus (output wr, addr, data, input rst_open, pwr_open, lp_open);
	modport guard (input wr, addr, data, output rst_open, pwr_open, lp_open);
endinterface : rpm_wr_if
